// [adc_link_cfg.svh]
// Timing and framing constants for the serial converter readout link
//
// How it works
// - Host makes the serial clock, max 2.1MHz
// - Host pulls select low, clock held low
// - Host waits 7.5us or result-line rise
// - Device drives line low converting, then high
// - Host gives at least 11 clocks after conversion
// - Device shifts MSB first on falling edges
// - Host samples result line on rising edges
// - Host raises select at/after 11th falling edge
// - Extra falling edges give sub-bits then zeros
// - Host keeps select high for minimum gap
// - After abort host waits the settle time
// - Frame: leading one, ten bits, sub-bits, zeros
// - Clock idles low, sample rise, change fall
// - Byte mode: two bytes, 1+7 then 3+2+3
// - Both framings keep clock under 2.097MHz
// - Host keeps clock low during conversion
// - Settle wait never below 1.5us
// - Trailing clocks give zeros, converter undisturbed
`ifndef ADC_LINK_CFG_SVH
`define ADC_LINK_CFG_SVH

`define CLK_PERIOD_NS      50
`define SCLK_MAX_KHZ       2097
`define CONV_TIME_NS       7500
`define DEV_CONV_TIME_NS   5000
`define SELECT_GAP_NS      500
`define TRACK_SETTLE_NS    1500

`define HALF_CYC  ((1000000 + 2 * `SCLK_MAX_KHZ * `CLK_PERIOD_NS - 1) / (2 * `SCLK_MAX_KHZ * `CLK_PERIOD_NS))
`define CONV_CYC  ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEV_CONV_CYC (`DEV_CONV_TIME_NS / `CLK_PERIOD_NS)
`define GAP_CYC   ((`SELECT_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CYC ((`TRACK_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define RESULT_BITS    10
`define SUB_BITS       2
`define WORD_BITS      12
`define CLOCKS_MIN     11
`define CLOCKS_BYTES   16
`define BYTE_BITS      8

`endif

// [adc_link_pkg.sv]
// State types shared by both ends of the converter readout link
package adc_link_pkg;

	typedef enum logic [1:0] {
		D_IDLE = 2'h0,
		D_CONV = 2'h1,
		D_DONE = 2'h3
	} dev_state_type;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_WAIT = 3'h1,
		H_LOW  = 3'h3,
		H_HIGH = 3'h2,
		H_GAP  = 3'h6
	} host_state_type;

endpackage : adc_link_pkg

// [adc_link_if.sv]
// Three-wire link between the readout host and the converter
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
	logic cs_n;
	logic sclk;
	logic dout;
	logic dout_oe;
	logic dout_line;

	// Undriven result line reads low
	assign dout_line = dout_oe ? dout : 1'b0;

	modport device (
		input  cs_n,
		input  sclk,
		output dout,
		output dout_oe
	);

	modport host (
		output cs_n,
		output sclk,
		input  dout_line
	);
endinterface : adc_link_if
`default_nettype wire

// [adc_serial_device.sv]
// Converter end: conversion timing on clk, result shifting on the link clock
`include "adc_link_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_serial_device (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	adc_link_if.device                    link,
	input  wire logic [`RESULT_BITS-1:0]  sample_data,
	input  wire logic [`SUB_BITS-1:0]     sub_bits,
	output logic                          conv_busy,
	output logic                          result_ready
);
	import adc_link_pkg::*;

	// ----------------------------------------
	// Select synchroniser and conversion timer
	// ----------------------------------------
	logic          cs1_q, cs2_q, cs3_q, cs_q;
	logic          cs1_d, cs2_d, cs3_d, cs_d;
	dev_state_type st_q, st_d;
	logic [7:0]    cnt_q, cnt_d;
	logic [`WORD_BITS-1:0] word_q, word_d;

	always_comb begin
		cs1_d = link.cs_n;
		cs2_d = cs1_q;
		cs3_d = cs2_q;
		cs_d = (cs2_q == cs3_q) ? cs3_q : cs_q;
		st_d = st_q;
		cnt_d = cnt_q;
		word_d = word_q;
		unique case (st_q)
			D_IDLE: begin
				cnt_d = 8'h00;
				if (!cs_d) begin
					st_d = D_CONV;
				end
			end
			D_CONV: begin
				cnt_d = cnt_q + 8'h01;
				if (cs_d) begin
					st_d = D_IDLE;
				end else if (cnt_q == 8'(`DEV_CONV_CYC - 1)) begin
					// Result held stable until select rises
					word_d = {sample_data, sub_bits};
					st_d = D_DONE;
				end
			end
			D_DONE: begin
				if (cs_d) begin
					st_d = D_IDLE;
				end
			end
			default: begin
				st_d = D_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cs1_q <= 1'b1;
			cs2_q <= 1'b1;
			cs3_q <= 1'b1;
			cs_q <= 1'b1;
			st_q <= D_IDLE;
			cnt_q <= 8'h00;
			word_q <= '0;
		end else begin
			cs1_q <= cs1_d;
			cs2_q <= cs2_d;
			cs3_q <= cs3_d;
			cs_q <= cs_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			word_q <= word_d;
		end
	end

	assign conv_busy = (st_q == D_CONV);
	assign result_ready = (st_q == D_DONE);

	// ----------------------------------------
	// Link-clock shifter, cleared by select high
	// ----------------------------------------
	// The word is read without a synchroniser: it is frozen from end of
	// conversion on, and the host keeps the clock still before then.
	logic                  link_rst_n;
	logic                  started_q, started_d;
	logic                  bit_q, bit_d;
	logic [`WORD_BITS-1:0] sh_q, sh_d;

	assign link_rst_n = nrst & ~link.cs_n;

	always_comb begin
		started_d = started_q;
		bit_d = bit_q;
		sh_d = sh_q;
		if (!started_q) begin
			if (result_ready) begin
				started_d = 1'b1;
				bit_d = word_q[`WORD_BITS-1];
				sh_d = {word_q[`WORD_BITS-2:0], 1'b0};
			end
		end else begin
			bit_d = sh_q[`WORD_BITS-1];
			sh_d = {sh_q[`WORD_BITS-2:0], 1'b0};
		end
	end

	always_ff @(negedge link.sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			started_q <= 1'b0;
			bit_q <= 1'b0;
			sh_q <= '0;
		end else begin
			started_q <= started_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
		end
	end

	// Leading one is the end-of-conversion level itself
	assign link.dout = started_q ? bit_q : result_ready;
	assign link.dout_oe = ~cs_q;
endmodule : adc_serial_device
`default_nettype wire

// [adc_serial_host.sv]
// Host end: select, divided serial clock, sampling and result assembly
`include "adc_link_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_serial_host (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	adc_link_if.host                      link,
	input  wire logic                     start,
	input  wire logic                     byte_mode,
	input  wire logic                     abort,
	output logic                          busy,
	output logic [`RESULT_BITS-1:0]       result,
	output logic                          result_valid,
	output logic [7:0]                    byte_hi,
	output logic [7:0]                    byte_lo,
	output logic                          timed_out
);
	import adc_link_pkg::*;

	// ----------------------------------------
	// Result line synchroniser
	// ----------------------------------------
	logic d1_q, d2_q, d3_q, dl_q;
	logic d1_d, d2_d, d3_d, dl_d;
	logic dout_rise;

	always_comb begin
		d1_d = link.dout_line;
		d2_d = d1_q;
		d3_d = d2_q;
		dl_d = (d2_q == d3_q) ? d3_q : dl_q;
	end

	assign dout_rise = dl_d & ~dl_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			d1_q <= 1'b0;
			d2_q <= 1'b0;
			d3_q <= 1'b0;
			dl_q <= 1'b0;
		end else begin
			d1_q <= d1_d;
			d2_q <= d2_d;
			d3_q <= d3_d;
			dl_q <= dl_d;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// The clock is a plain divider of clk, so both phases are whole
	// multiples of the clk period and the rate stays under the limit.
	host_state_type             st_q, st_d;
	logic [7:0]                 cnt_q, cnt_d;
	logic [4:0]                 nclk_q, nclk_d;
	logic [4:0]                 total_q, total_d;
	logic [7:0]                 gap_q, gap_d;
	logic [`CLOCKS_BYTES-1:0]   rx_q, rx_d;
	logic                       cs_n_q, cs_n_d;
	logic                       sclk_q, sclk_d;
	logic [`RESULT_BITS-1:0]    res_q, res_d;
	logic                       val_q, val_d;
	logic [7:0]                 bhi_q, bhi_d;
	logic [7:0]                 blo_q, blo_d;
	logic                       tmo_q, tmo_d;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		nclk_d = nclk_q;
		total_d = total_q;
		gap_d = gap_q;
		rx_d = rx_q;
		cs_n_d = cs_n_q;
		sclk_d = sclk_q;
		res_d = res_q;
		val_d = 1'b0;
		bhi_d = bhi_q;
		blo_d = blo_q;
		tmo_d = tmo_q;
		unique case (st_q)
			H_IDLE: begin
				sclk_d = 1'b0;
				if (start) begin
					cs_n_d = 1'b0;
					cnt_d = 8'h00;
					nclk_d = 5'h00;
					rx_d = 16'h0000;
					total_d = byte_mode ? 5'(`CLOCKS_BYTES) : 5'(`CLOCKS_MIN);
					st_d = H_WAIT;
				end
			end
			H_WAIT: begin
				// Clock held low until conversion ends
				sclk_d = 1'b0;
				cnt_d = cnt_q + 8'h01;
				if (abort) begin
					cs_n_d = 1'b1;
					cnt_d = 8'h00;
					gap_d = 8'(`SETTLE_CYC);
					st_d = H_GAP;
				end else if (dout_rise || cnt_q == 8'(`CONV_CYC - 1)) begin
					tmo_d = ~dout_rise;
					cnt_d = 8'h00;
					st_d = H_LOW;
				end
			end
			H_LOW: begin
				cnt_d = cnt_q + 8'h01;
				if (cnt_q == 8'(`HALF_CYC - 1)) begin
					cnt_d = 8'h00;
					sclk_d = 1'b1;
					// Sample on the rising edge the host itself makes
					rx_d = {rx_q[`CLOCKS_BYTES-2:0], dl_q};
					st_d = H_HIGH;
				end
			end
			H_HIGH: begin
				cnt_d = cnt_q + 8'h01;
				if (cnt_q == 8'(`HALF_CYC - 1)) begin
					cnt_d = 8'h00;
					sclk_d = 1'b0;
					nclk_d = nclk_q + 5'h01;
					if (nclk_q == total_q - 5'h01) begin
						// Select rises with the last falling edge
						cs_n_d = 1'b1;
						gap_d = 8'(`GAP_CYC);
						val_d = 1'b1;
						if (total_q == 5'(`CLOCKS_MIN)) begin
							res_d = rx_q[`RESULT_BITS-1:0];
							bhi_d = rx_q[`RESULT_BITS -: `BYTE_BITS];
							blo_d = rx_q[`BYTE_BITS-1:0] << (`CLOCKS_BYTES - `CLOCKS_MIN);
						end else begin
							res_d = rx_q[`CLOCKS_BYTES-2 -: `RESULT_BITS];
							bhi_d = rx_q[`CLOCKS_BYTES-1 -: `BYTE_BITS];
							blo_d = rx_q[`BYTE_BITS-1:0];
						end
						st_d = H_GAP;
					end else begin
						st_d = H_LOW;
					end
				end
			end
			H_GAP: begin
				cnt_d = cnt_q + 8'h01;
				if (cnt_q == gap_q - 8'h01) begin
					cnt_d = 8'h00;
					st_d = H_IDLE;
				end
			end
			default: begin
				st_d = H_IDLE;
				cs_n_d = 1'b1;
				sclk_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= H_IDLE;
			cnt_q <= 8'h00;
			nclk_q <= 5'h00;
			total_q <= 5'h00;
			gap_q <= 8'h00;
			rx_q <= 16'h0000;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			res_q <= '0;
			val_q <= 1'b0;
			bhi_q <= 8'h00;
			blo_q <= 8'h00;
			tmo_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			nclk_q <= nclk_d;
			total_q <= total_d;
			gap_q <= gap_d;
			rx_q <= rx_d;
			cs_n_q <= cs_n_d;
			sclk_q <= sclk_d;
			res_q <= res_d;
			val_q <= val_d;
			bhi_q <= bhi_d;
			blo_q <= blo_d;
			tmo_q <= tmo_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.cs_n = cs_n_q;
	assign link.sclk = sclk_q;
	assign busy = (st_q != H_IDLE);
	assign result = res_q;
	assign result_valid = val_q;
	assign byte_hi = bhi_q;
	assign byte_lo = blo_q;
	assign timed_out = tmo_q;
endmodule : adc_serial_host
`default_nettype wire

// [adc_serial_readout_assertions.sv]
// Link-level assertions for the converter readout link
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_assertions (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic dout_line
);
	// --------
	// Helpers
	// --------
	logic       seen_q, seen_d, ab_q, ab_d, sclk_q;
	logic [7:0] cnt_q, cnt_d, hi_q, hi_d;
	logic [4:0] nf_q, nf_d;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	always_comb begin
		seen_d = !cs_n && (seen_q || dout_line);
		cnt_d = cs_n ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hff};
		hi_d = cs_n ? hi_q + {7'h00, hi_q != 8'hff} : 8'h00;
		nf_d = cs_n ? 5'h00 : nf_q + {4'h0, sclk_q && !sclk};
		// Abort is a select rise before the end of conversion was seen
		ab_d = (cs_n && hi_q == 8'h00) ? !seen_q : ab_q;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{seen_q, ab_q, sclk_q, cnt_q, nf_q} <= '0;
			hi_q <= 8'hff;
		end else begin
			{seen_q, ab_q, sclk_q, cnt_q, hi_q, nf_q} <= {seen_d, ab_d, sclk, cnt_d, hi_d, nf_d};
		end
	end
	// --------
	// Checks
	// --------
	sequence conv_start;
		$fell(cs_n);
	endsequence
	sequence drive_low;
		##[1:5] (dout_oe && !dout);
	endsequence
	AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
		else $error("serial clock high while deselected");
	AST_START_CLK_LOW: assert property (conv_start |-> !sclk)
		else $error("serial clock high at conversion start");
	AST_NO_CLK_CONV: assert property ((!cs_n && !seen_q) |-> !sclk)
		else $error("serial clock ran during conversion");
	AST_HIGH_PHASE: assert property ($rose(sclk) |-> sclk[*5] ##1 !sclk)
		else $error("serial clock high phase not five cycles");
	AST_LOW_PHASE: assert property (($fell(sclk) && !cs_n) |-> !sclk[*5])
		else $error("serial clock low phase too short");
	AST_DRIVE_LOW: assert property (conv_start |-> drive_low)
		else $error("result line not driven low after select");
	AST_EOC_TIME: assert property (($rose(dout_line) && !seen_q && !cs_n)
		|-> (cnt_q >= 8'd96 && cnt_q <= 8'd110))
		else $error("end of conversion at wrong time");
	AST_SHIFT_EDGE: assert property ((seen_q && !cs_n && $changed(dout_line))
		|-> $fell(sclk))
		else $error("result line changed off a falling clock");
	AST_TRAIL_ZERO: assert property (($fell(sclk) && !cs_n && nf_q >= 5'd12)
		|-> !dout_line)
		else $error("trailing bit not zero");
	AST_CS_RELEASE: assert property (($rose(cs_n) && seen_q)
		|-> (nf_q >= 5'd10 && $fell(sclk)))
		else $error("select raised before eleventh falling edge");
	AST_GAP: assert property (conv_start |-> hi_q >= (ab_q ? 8'd30 : 8'd10))
		else $error("select high gap too short");
	AST_OE_RELEASE: assert property ($rose(cs_n) |-> ##[1:5] !dout_oe)
		else $error("result line still driven after deselect");
endmodule : adc_serial_readout_assertions
`default_nettype wire

// [adc_serial_readout_tb.sv]
// Self-checking bench joining host and converter ends
`include "adc_link_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_tb;
	logic                    clk = 1'b0, nrst = 1'b0, start = 1'b0;
	logic                    byte_mode = 1'b0, abort = 1'b0;
	logic [`RESULT_BITS-1:0] sample_data = '0, result;
	logic [`SUB_BITS-1:0]    sub_bits = '0;
	logic                    busy, result_valid, timed_out, conv_busy, result_ready;
	logic [7:0]              byte_hi, byte_lo;
	logic [15:0]             wire_q = '0;
	logic [31:0]             rng = 32'h27b1_e5fd;
	logic [47:0]             notes[$];
	int                      failures = 0, n_compared = 0, cycles = 0;
	adc_link_if link ();
	adc_serial_host i_adc_serial_host (.clk(clk), .nrst(nrst), .link(link.host),
		.start(start), .byte_mode(byte_mode), .abort(abort), .busy(busy),
		.result(result), .result_valid(result_valid), .byte_hi(byte_hi),
		.byte_lo(byte_lo), .timed_out(timed_out));
	adc_serial_device i_adc_serial_device (.clk(clk), .nrst(nrst), .link(link.device),
		.sample_data(sample_data), .sub_bits(sub_bits), .conv_busy(conv_busy),
		.result_ready(result_ready));
	adc_serial_readout_assertions i_adc_serial_readout_assertions (.clk(clk),
		.nrst(nrst), .cs_n(link.cs_n), .sclk(link.sclk), .dout(link.dout),
		.dout_oe(link.dout_oe), .dout_line(link.dout_line));
	// --------
	// Helpers
	// --------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic end_sim;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic wait_idle;
		for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
		// A host stuck busy is a hang: count it and report at once
		if (busy !== 1'b0) begin
			failures++;
			end_sim();
		end
	endtask : wait_idle
	// A second start mid-frame must be ignored; an extra result would drain the queue
	task automatic frame(input logic bm);
		logic [12:0] f;
		logic [47:0] e;
		rng = xs(rng);
		f = {1'b1, rng[9:0], bm ? rng[11:10] : 2'b00};
		e = {6'h00, rng[9:0], f[12:5], f[4:0], 3'h0, bm ? {f, 3'h0} : {5'h00, f[12:2]}};
		@(posedge clk);
		sample_data <= rng[9:0];
		sub_bits <= rng[11:10];
		byte_mode <= bm;
		start <= 1'b1;
		notes.push_back(e);
		@(posedge clk);
		start <= 1'b0;
		repeat (8) @(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		wait_idle();
		$display("frame done, byte mode %0d", bm);
	endtask : frame
	task automatic abort_run;
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (20) @(posedge clk);
		check({47'h0, conv_busy}, 48'h1);
		abort <= 1'b1;
		@(posedge clk);
		abort <= 1'b0;
		wait_idle();
		check({44'h0, busy, link.cs_n, conv_busy, result_ready}, 48'h4);
		$display("abort done");
	endtask : abort_run
	// --------
	// Monitors
	// --------
	// One driver: select falls with the clock low, a sampling edge has it high
	always @(posedge link.sclk or negedge link.cs_n) begin
		wire_q <= link.sclk ? {wire_q[14:0], link.dout_line} : 16'h0000;
	end
	always @(posedge clk) begin
		if (result_valid === 1'b1) begin
			check({5'h00, timed_out, result, byte_hi, byte_lo, wire_q},
				notes.size() ? notes.pop_front() : 48'hx);
		end
	end
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles > 6000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		frame(1'b0);
		frame(1'b1);
		abort_run();
		for (int i = 0; i < 6; i++) frame(rng[13]);
		check({47'h0, notes.size() == 0}, 48'h1);
		end_sim();
	end
endmodule : adc_serial_readout_tb
`default_nettype wire
